/* rtl/spi_port_pkg.sv */
// Purpose: Shared constants and types for the sensor serial slave port.
// Assumes: Single 250 MHz core clock; serial link sampled as ordinary inputs.
// Notes:   Register file outside this block is reached via a request struct and an 8-bit read data input.
`default_nettype none
package spi_port_pkg;
  // ************************************************************
  // Frame layout
  // ************************************************************
  localparam int unsigned CMD_BITS       = 8;
  localparam int unsigned DATA_BITS      = 8;
  localparam logic [3:0]  DIR_BIT_POS    = 4'h0;
  localparam logic [3:0]  HOLD_BIT_POS   = 4'h1;
  localparam logic [3:0]  FIRST_DATA_BIT = 4'h8;
  localparam logic        DIR_READ       = 1'b1;
  localparam logic        DIR_WRITE      = 1'b0;
  // ************************************************************
  // Bus address and reset values
  // ************************************************************
  localparam logic [6:0]  BUS_BASE_ADDR  = 7'h58;
  localparam logic [5:0]  BUS_BASE_6BIT  = 6'h2C;
  localparam logic [5:0]  CFG_REG_INDEX  = 6'h16;
  localparam logic        THREE_WIRE_RST = 1'b0;
  localparam logic [7:0]  BYTE_RST       = 8'h00;
  localparam logic [5:0]  INDEX_RST      = 6'h00;
  localparam logic [2:0]  BITCNT_RST     = 3'h0;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] index;
    logic [7:0] wdata;
  } reg_req_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CMD  = 3'b010,
    ST_DATA = 3'b100
  } frame_state_t;
endpackage : spi_port_pkg
`default_nettype wire

/* rtl/sensor_serial_slave_port.sv */
// Purpose: Serial slave port giving register access over a 3- or 4-wire link.
// Assumes: Link pins are asynchronous; serial clock idles low; register file answers reads in same cycle.
// Notes:   Bits are taken at rising serial clock edges and shifted out after falling edges.
`default_nettype none
module sensor_serial_slave_port (
  input  wire logic                      clk_i,              // Core clock, 250 MHz
  input  wire logic                      reset_n_i,          // Async reset, active low
  input  wire logic                      sel_n_i,            // Chip select pin, active low
  input  wire logic                      sclk_i,             // Serial clock pin
  input  wire logic                      sdi_i,              // Shared data pin, input side
  output logic                           sdi_o,              // Shared data pin, output side
  output logic                           sdi_oe_n_o,         // Shared data pin enable, low drives
  output logic                           sdo_o,              // Separate data out
  output logic                           sdo_oe_n_o,         // Separate data out enable, low drives
  input  wire logic                      address_lsb_pin_i,  // Address-select strap
  input  wire logic                      three_wire_i,       // Configuration bit for half duplex
  output logic [6:0]                     bus_addr_o,         // Two-wire bus slave address
  output spi_port_pkg::reg_req_t         req_o,              // Register write request pulse and read index; rd stays low
  input  wire logic [7:0]                rdata_i,            // Register read data for req_o.index
  output logic                           selected_o          // Port currently selected
);
  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [1:0] sel_s_q, clk_s_q, din_s_q, addr_s_q;
  logic       clk_prev_q;
  // Select resets high and clock history low, matching idle pins, so no false edge follows reset
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sel_s_q    <= 2'h3;
      clk_s_q    <= 2'h0;
      din_s_q    <= 2'h0;
      addr_s_q   <= 2'h0;
      clk_prev_q <= 1'b0;
    end else begin
      sel_s_q    <= {sel_s_q[0], sel_n_i};
      clk_s_q    <= {clk_s_q[0], sclk_i};
      din_s_q    <= {din_s_q[0], sdi_i};
      addr_s_q   <= {addr_s_q[0], address_lsb_pin_i};
      clk_prev_q <= clk_s_q[1];
    end
  end

  wire selected   = ~sel_s_q[1];
  wire rise       = selected & clk_s_q[1] & ~clk_prev_q;
  wire fall       = selected & ~clk_s_q[1] & clk_prev_q;
  wire din        = din_s_q[1];

  // ************************************************************
  // Frame state
  // ************************************************************
  spi_port_pkg::frame_state_t state_q, state_d;
  logic [2:0] bit_q;
  logic [6:0] cmd_q;
  logic       is_read_q, hold_q, drive_q, three_q;
  logic [5:0] index_q;
  logic [7:0] shin_q, shout_q;
  // bit_q wraps every eight rising edges; a cut trailing byte never reaches data_done and is dropped

  wire byte_done  = rise & (bit_q == 3'h7);
  wire cmd_done   = (state_q == spi_port_pkg::ST_CMD) & byte_done;
  wire data_done  = (state_q == spi_port_pkg::ST_DATA) & byte_done;
  wire [5:0] cmd_index = {cmd_q[4:0], din};
  wire       cmd_read  = cmd_q[6];
  wire       cmd_hold  = cmd_q[5];
  wire [5:0] next_index = hold_q ? index_q : index_q + 6'h01;
  wire       load_out   = (cmd_done & cmd_read) | (data_done & is_read_q);
  wire [5:0] load_index = cmd_done ? cmd_index : next_index;

  always_comb begin
    state_d = state_q;
    case (state_q)
      spi_port_pkg::ST_IDLE: if (selected) state_d = spi_port_pkg::ST_CMD;
      spi_port_pkg::ST_CMD:  if (!selected) state_d = spi_port_pkg::ST_IDLE;
                             else if (cmd_done) state_d = spi_port_pkg::ST_DATA;
      spi_port_pkg::ST_DATA: if (!selected) state_d = spi_port_pkg::ST_IDLE;
      default:               state_d = spi_port_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= spi_port_pkg::ST_IDLE;
      bit_q   <= spi_port_pkg::BITCNT_RST;
      cmd_q   <= 7'h00;
      shin_q  <= spi_port_pkg::BYTE_RST;
    end else begin
      state_q <= state_d;
      if (!selected) begin
        bit_q <= spi_port_pkg::BITCNT_RST;
      end else if (rise) begin
        bit_q <= bit_q + 3'h1;
        if (state_q == spi_port_pkg::ST_CMD) begin
          cmd_q <= {cmd_q[5:0], din};
        end else begin
          shin_q <= {shin_q[6:0], din};
        end
      end
    end
  end

  // Index and direction latch at end of command byte, index steps after each data byte unless the hold bit is set
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      is_read_q <= spi_port_pkg::DIR_WRITE;
      hold_q    <= 1'b0;
      index_q   <= spi_port_pkg::INDEX_RST;
    end else if (cmd_done) begin
      is_read_q <= cmd_read;
      hold_q    <= cmd_hold;
      index_q   <= cmd_read ? cmd_index : cmd_index;
    end else if (data_done) begin
      index_q   <= next_index;
    end
  end

  // ************************************************************
  // Register access
  // ************************************************************
  // A write lands only on a whole data byte; the index steps in the same cycle
  wire write_now = data_done & ~is_read_q;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      req_o <= '0;
    end else begin
      req_o.wr    <= write_now;
      req_o.rd    <= 1'b0;
      req_o.wdata <= {shin_q[6:0], din};
      req_o.index <= write_now ? index_q : load_index;
    end
  end

  // ************************************************************
  // Output shifter and pin drivers
  // ************************************************************
  // Data loads one cycle after the index is presented so rdata_i has settled
  logic load_pend_q;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      load_pend_q <= 1'b0;
      shout_q     <= spi_port_pkg::BYTE_RST;
      drive_q     <= 1'b0;
      three_q     <= spi_port_pkg::THREE_WIRE_RST;
    end else begin
      three_q     <= three_wire_i;
      load_pend_q <= load_out & selected;
      if (!selected) begin
        drive_q <= 1'b0;
      end else if (load_pend_q) begin
        shout_q <= rdata_i;
      end else if (fall & (state_q == spi_port_pkg::ST_DATA) & is_read_q) begin
        drive_q <= 1'b1;
        if (bit_q != 3'h0) shout_q <= {shout_q[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sdo_o      <= 1'b0;
      sdo_oe_n_o <= 1'b1;
      sdi_o      <= 1'b0;
      sdi_oe_n_o <= 1'b1;
      selected_o <= 1'b0;
      bus_addr_o <= spi_port_pkg::BUS_BASE_ADDR;
    end else begin
      sdo_o      <= shout_q[7];
      sdi_o      <= shout_q[7];
      sdo_oe_n_o <= ~(drive_q & selected & ~three_q);
      sdi_oe_n_o <= ~(drive_q & selected & three_q);
      selected_o <= selected;
      bus_addr_o <= {spi_port_pkg::BUS_BASE_6BIT, addr_s_q[1]};
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence deselect_s;
    $rose(sel_s_q[1]);
  endsequence

  sdo_float_a:     assert property (sel_s_q[1] & $past(sel_s_q[1]) |=> sdo_oe_n_o & sdi_oe_n_o)
    else $error("data output driven while deselected");
  end_float_a:     assert property (deselect_s |-> ##2 sdo_oe_n_o & sdi_oe_n_o)
    else $error("output not released after frame end");
  three_wire_a:    assert property (three_q |=> sdo_oe_n_o)
    else $error("separate output driven in three-wire mode");
  bus_addr_a:      assert property (bus_addr_o[6:1] == spi_port_pkg::BUS_BASE_6BIT)
    else $error("bus address base wrong");
  no_cmd_drive_a:  assert property (state_q == spi_port_pkg::ST_CMD |-> !drive_q)
    else $error("output driven during command bits");
  write_pulse_a:   assert property (req_o.wr |=> !req_o.wr)
    else $error("write request longer than one cycle");
  write_dir_a:     assert property (write_now |-> !is_read_q && state_q == spi_port_pkg::ST_DATA)
    else $error("write issued for read frame");
  hold_index_a:    assert property (data_done && hold_q |=> index_q == $past(index_q))
    else $error("held index changed");

  // ************************************************************
  // Command byte and register request checks
  // ************************************************************
  // Each check looks one cycle past the launching edge, so a request that
  // slips by a cycle fails here even when the frame still ends cleanly.
  sequence fetch_req_s;
    load_out;
  endsequence

  sequence fetch_taken_s;
    ##1 load_pend_q;
  endsequence

  sequence write_byte_s;
    write_now;
  endsequence

  sequence write_pulse_s;
    ##1 req_o.wr;
  endsequence

  read_fetch_a:    assert property (
      fetch_req_s |-> fetch_taken_s)
    else $error("read data fetch not scheduled");
  write_issue_a:   assert property (
      write_byte_s |-> write_pulse_s)
    else $error("write request missing after data byte");
  read_load_a:     assert property (
      cmd_done && cmd_read |=> req_o.index == $past(cmd_index))
    else $error("read index not presented after command");
  dir_latch_a:     assert property (
      cmd_done |=> is_read_q == $past(cmd_read) && hold_q == $past(cmd_hold))
    else $error("direction or hold bit not latched");
  cmd_no_write_a:  assert property (
      cmd_done |=> !req_o.wr)
    else $error("write request during command byte");
  read_no_write_a: assert property (
      data_done && is_read_q |=> !req_o.wr)
    else $error("write request in read frame");
  write_index_a:   assert property (
      write_now |=> req_o.index == $past(index_q))
    else $error("write index wrong");
  write_data_a:    assert property (
      write_now |=> req_o.wdata == $past({shin_q[6:0], din}))
    else $error("write data wrong");
  incr_index_a:    assert property (
      data_done && !hold_q |=> index_q == $past(index_q) + 6'h01)
    else $error("index did not step after byte");
  bit_count_a:     assert property (
      rise |=> bit_q == $past(bit_q) + 3'h1)
    else $error("bit counter did not step");

  // ************************************************************
  // Shifter and pin checks
  // ************************************************************
  // The shifter must never move while a fetch lands, or the byte loses its MSB.
  shout_load_a:    assert property (
      load_pend_q && selected |=> shout_q == $past(rdata_i))
    else $error("read byte not loaded");
  out_shift_a:     assert property (
      fall && state_q == spi_port_pkg::ST_DATA && is_read_q && !load_pend_q && bit_q != 3'h0
        |=> shout_q == {$past(shout_q[6:0]), 1'b0})
    else $error("read byte not shifted");
  drive_start_a:   assert property (
      fall && state_q == spi_port_pkg::ST_DATA && is_read_q && !load_pend_q |=> drive_q)
    else $error("read drive not started");
  out_follow_a:    assert property (
      drive_q |=> sdo_o == $past(shout_q[7]) && sdi_o == $past(shout_q[7]))
    else $error("data pins do not follow shifter");
  deselect_idle_a: assert property (
      !selected |=> state_q == spi_port_pkg::ST_IDLE && bit_q == spi_port_pkg::BITCNT_RST)
    else $error("frame not ended by deselect");
  ignore_din_a:    assert property (
      !selected |=> $stable(cmd_q) && $stable(shin_q))
    else $error("data input taken while deselected");
  four_wire_a:     assert property (
      !three_q |=> sdi_oe_n_o)
    else $error("shared pin driven in four-wire mode");
endmodule : sensor_serial_slave_port
`default_nettype wire

/* bench/spi_master_model.sv */
// Purpose: Serial master model that runs command frames into the slave port.
// Assumes: Serial clock idles low, half period 80 ns; data changes after falling edges.
// Notes:   An undriven shared pin shows the inverse of its last level.
`default_nettype none
module spi_master_model (
  output logic      sel_n_o,    // Chip select, active low
  output logic      sclk_o,     // Serial clock
  output logic      pin_o,      // Resolved shared data pin
  input  wire logic dev_d_i,    // Device shared pin value
  input  wire logic dev_oe_n_i, // Device shared pin enable, low drives
  input  wire logic so_i        // Device separate data out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv_q = 1'h0;
  logic bit_q = 1'h0;
  logic last_q = 1'h0;
  initial sel_n_o = 1'h1;
  initial sclk_o = 1'h0;
  // Keeping the last driven level apart from the pin avoids a zero-delay loop
  always @* if (!dev_oe_n_i) last_q = dev_d_i; else if (drv_q) last_q = bit_q;
  assign pin_o = !dev_oe_n_i ? dev_d_i : (drv_q ? bit_q : !last_q);
  // ************************************************************
  // One frame; en low keeps the port deselected while clocking
  // ************************************************************
  task automatic frame(input logic en, input logic [31:0] tx, input int n, input logic tw,
                       output logic [23:0] rx);
    rx = '0;
    bit_q = tx[31];
    drv_q = 1'h1;
    #80 sel_n_o = !en;
    for (int i = 0; i < n; i++) begin
      bit_q = tx[31-i];
      #80 sclk_o = 1'h1;
      if (i >= 8) rx = {rx[22:0], tw ? pin_o : so_i};
      #80 sclk_o = 1'h0;
      if (i == 7 && tw && tx[31]) drv_q = 1'h0;
    end
    #80 sel_n_o = 1'h1;
    drv_q = 1'h0;
  endtask : frame
endmodule : spi_master_model
`default_nettype wire

/* bench/sensor_serial_slave_port_test.sv */
// Purpose: Self-checking bench for the serial slave port.
// Assumes: Register file modelled here answers reads combinationally.
// Notes:   Expected register contents are kept in a separate shadow array.
`default_nettype none
module sensor_serial_slave_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic tw; logic rd; logic hold; logic [5:0] idx; logic [1:0] nb; logic [23:0] wd;
  } row_t;
  row_t rows [7] = '{'{1'h0, 1'h0, 1'h0, 6'h3E, 2'h3, 24'h112233}, '{1'h0, 1'h1, 1'h0, 6'h3E, 2'h3, 24'h0},
                     '{1'h0, 1'h0, 1'h1, 6'h05, 2'h2, 24'h445500}, '{1'h0, 1'h1, 1'h1, 6'h05, 2'h2, 24'h0},
                     '{1'h1, 1'h0, 1'h0, 6'h10, 2'h1, 24'h660000}, '{1'h1, 1'h1, 1'h0, 6'h0F, 2'h3, 24'h0},
                     '{1'h1, 1'h1, 1'h1, 6'h10, 2'h1, 24'h0}};
  logic clk_i = 1'h0;
  logic reset_n_i = 1'h0;
  logic strap = 1'h0;
  logic tw = 1'h0;
  logic sel_n, sclk, pin, sdi_o, sdi_oe_n, sdo, sdo_oe_n, selected, oe_bad;
  logic [6:0] bus_addr;
  logic [7:0] rdata;
  logic [7:0] regs [64];
  logic [7:0] expm [64];
  logic [23:0] rx, ex;
  logic [5:0] a;
  spi_port_pkg::reg_req_t req;
  int fail_count, samples_checked, wr_seen, wr0;
  always #2 clk_i = ~clk_i;
  spi_master_model m (.sel_n_o(sel_n), .sclk_o(sclk), .pin_o(pin), .dev_d_i(sdi_o), .dev_oe_n_i(sdi_oe_n),
                      .so_i(sdo));
  sensor_serial_slave_port dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .sel_n_i(sel_n), .sclk_i(sclk),
    .sdi_i(pin), .sdi_o(sdi_o), .sdi_oe_n_o(sdi_oe_n), .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n),
    .address_lsb_pin_i(strap), .three_wire_i(tw), .bus_addr_o(bus_addr), .req_o(req), .rdata_i(rdata),
    .selected_o(selected));
  assign rdata = regs[req.index];
  initial oe_bad = 1'h0;
  always @(posedge clk_i) begin
    if (req.wr === 1'h1) begin
      regs[req.index] <= req.wdata;
      wr_seen++;
    end
    if (reset_n_i && (tw ? sdo_oe_n : sdi_oe_n) !== 1'h1) oe_bad <= 1'h1;
  end
  // ************************************************************
  // Checking and closing
  // ************************************************************
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  // Select release needs about 3 cycles, enables follow within 4 more
  task automatic settle();
    int k;
    k = 0;
    while (selected !== 1'h0 && k < 20) begin
      @(posedge clk_i);
      k++;
    end
    if (k == 20) begin
      fail_count++;
      close_out();
    end
    repeat (4) @(posedge clk_i);
  endtask : settle
  initial begin
    for (int i = 0; i < 64; i++) regs[i] = 8'(i) ^ 8'hA5;
    for (int i = 0; i < 64; i++) expm[i] = 8'(i) ^ 8'hA5;
    repeat (6) @(posedge clk_i);
    #1 reset_n_i = 1'h1;
    repeat (4) @(posedge clk_i);
    chk("bus address", {spi_port_pkg::BUS_BASE_6BIT, 1'h0}, bus_addr);
    chk("idle enables", 2'h3, {sdo_oe_n, sdi_oe_n});
    foreach (rows[j]) begin
      @(posedge clk_i);
      #1 tw = rows[j].tw;
      wr0 = wr_seen;
      m.frame(1'h1, {rows[j].rd, rows[j].hold, rows[j].idx, rows[j].wd}, 8 + 8 * int'(rows[j].nb), tw, rx);
      settle();
      ex = '0;
      for (int k = 0; k < rows[j].nb; k++) begin
        a = rows[j].idx + (rows[j].hold ? 6'h00 : 6'(k));
        if (rows[j].rd) ex = {ex[15:0], expm[a]};
        else expm[a] = rows[j].wd[23-8*k -: 8];
      end
      if (rows[j].rd) chk("read data", ex, rx);
      else chk("write count", 24'(rows[j].nb), 24'(wr_seen - wr0));
      chk("released enables", 2'h3, {sdo_oe_n, sdi_oe_n});
    end
    wr0 = wr_seen;
    #1 m.frame(1'h0, 32'h0155AAFF, 32, tw, rx);
    settle();
    chk("deselected writes", 24'h0, 24'(wr_seen - wr0));
    #1 m.frame(1'h1, 32'h07778800, 20, tw, rx);
    settle();
    chk("partial byte writes", 24'h1, 24'(wr_seen - wr0));
    #1 reset_n_i = 1'h0;
    repeat (6) @(posedge clk_i);
    #1 reset_n_i = 1'h1;
    @(posedge clk_i);
    #1 chk("reset enables", 24'h3, 24'({sdo_oe_n, sdi_oe_n}));
    chk("read strobe", 24'h0, 24'(req.rd));
    @(posedge clk_i);
    #1 chk("reset write strobe", 24'h0, 24'(req.wr));
    repeat (2) @(posedge clk_i);
    #1 m.frame(1'h1, {1'h1, 1'h1, 6'h10, 24'h0}, 16, tw, rx);
    settle();
    chk("read after reset", {16'h0, expm[6'h10]}, rx);
    chk("unused pin enable", 24'h0, 24'(oe_bad));
    @(posedge clk_i);
    #1 strap = 1'h1;
    for (int k = 0; k < 10 && bus_addr !== {spi_port_pkg::BUS_BASE_6BIT, 1'h1}; k++) @(posedge clk_i);
    chk("strapped address", {spi_port_pkg::BUS_BASE_6BIT, 1'h1}, bus_addr);
    close_out();
  end
endmodule : sensor_serial_slave_port_test
`default_nettype wire
